//--- srsd_pkg.sv
package srsd_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_BURST  = 12'h13E;
  localparam logic [ADDR_W-1:0] OFS_POWER  = 12'h140;
  localparam logic [ADDR_W-1:0] OFS_SYNC   = 12'h143;
  localparam logic [ADDR_W-1:0] OFS_DIVBLK = 12'h144;
  // burst_length_control fields
  localparam int unsigned BL_CODE_LSB = 0;
  localparam int unsigned BL_SRC_LSB  = 2;
  // sysref_power_control fields
  localparam int unsigned PW_PLSR_PD = 0;
  localparam int unsigned PW_DDLY_PD = 1;
  localparam int unsigned PW_SR_PD   = 2;
  // sync_control fields
  localparam int unsigned SC_POL     = 0;
  localparam int unsigned SC_MODE_LSB = 1;
  localparam int unsigned SC_REQ_EN  = 3;
  localparam int unsigned SC_SYNC_EN = 4;
  localparam int unsigned SC_CLR     = 5;
  localparam int unsigned SC_SRBLK   = 6;
  localparam int unsigned SC_CLR_OK  = 7;
  localparam logic [DATA_W-1:0] RST_BURST = 8'h00;
  localparam logic [DATA_W-1:0] RST_POWER = 8'h07;
  localparam logic [DATA_W-1:0] RST_SYNC  = 8'h20;
  localparam logic [DATA_W-1:0] RST_DIVBLK = 8'h00;
  localparam logic [4:0] CLR_CYCLES = 5'h0F;
  localparam logic [9:0] DDLY_MIN   = 10'h008;
  localparam logic [1:0] MUX_REF = 2'h0;
  localparam logic [1:0] MUX_RECLK = 2'h1;
  localparam logic [1:0] MUX_PLSR = 2'h2;
  localparam logic [1:0] MUX_CONT = 2'h3;
  typedef enum logic [1:0] {
    SRSD_MODE_OFF  = 2'b00,
    SRSD_MODE_PIN  = 2'b01,
    SRSD_MODE_PLSP = 2'b10,
    SRSD_MODE_PLSW = 2'b11
  } srsd_mode_e;
  typedef struct packed {
    logic [9:0] div;
    logic [9:0] ddly;
    logic       hs;
  } srsd_dclk_cfg_s;
endpackage

//--- srsd_top.sv
`timescale 1ns/1ps
module srsd_top #(
  parameter int unsigned NDIV     = 4,
  parameter int unsigned SR_DIV_W = 13,
  parameter int unsigned LDLY_W   = 4
) (
  input  wire logic                           clk_i,
  input  wire logic                           arst_n_i,
  input  wire logic                           reg_wr_i,
  input  wire logic [srsd_pkg::ADDR_W-1:0]    reg_addr_i,
  input  wire logic [srsd_pkg::DATA_W-1:0]    reg_wdata_i,
  output logic      [srsd_pkg::DATA_W-1:0]    reg_rdata_o,
  input  wire logic                           sync_pin_i,
  input  wire logic                           reference_input_zero_i,
  input  wire logic                           dist_clk_present_i,
  input  wire logic [SR_DIV_W-1:0]            sysref_divide_i,
  input  wire logic [LDLY_W-1:0]              local_sysref_delay_i,
  input  wire srsd_pkg::srsd_dclk_cfg_s [NDIV-1:0] dclk_cfg_i,
  output logic      [NDIV-1:0]                dclk_o,
  output logic      [NDIV-1:0]                half_step_o,
  output logic                                sysref_o,
  output logic                                sync_path_o
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] meta_reg, meta_next, syn_reg, syn_next;
  always_comb begin
    meta_next = {dist_clk_present_i, reference_input_zero_i, sync_pin_i};
    syn_next  = meta_reg;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= '0;
      syn_reg  <= '0;
    end else begin
      meta_reg <= meta_next;
      syn_reg  <= syn_next;
    end
  end
  logic pin_s, ref_s, clk_ok_s;
  assign pin_s    = syn_reg[0];
  assign ref_s    = syn_reg[1];
  assign clk_ok_s = syn_reg[2];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // writes land on this clock, so they already sit in the distribution domain
  logic [srsd_pkg::DATA_W-1:0] burst_reg, burst_next, power_reg, power_next;
  logic [srsd_pkg::DATA_W-1:0] sync_reg, sync_next, divblk_reg, divblk_next;
  logic [srsd_pkg::DATA_W-1:0] rdata_next;
  logic [4:0] clr_cnt_reg, clr_cnt_next;
  logic       clr_ok_reg, clr_ok_next, burst_wr;
  always_comb begin
    burst_next  = burst_reg;
    power_next  = power_reg;
    sync_next   = sync_reg;
    divblk_next = divblk_reg;
    burst_wr    = 1'b0;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        srsd_pkg::OFS_BURST: begin
          burst_next = reg_wdata_i;
          burst_wr   = 1'b1;
        end
        srsd_pkg::OFS_POWER:  power_next  = reg_wdata_i;
        srsd_pkg::OFS_SYNC:   sync_next   = reg_wdata_i;
        srsd_pkg::OFS_DIVBLK: divblk_next = reg_wdata_i;
        default: ;
      endcase
    end
    sync_next[srsd_pkg::SC_CLR_OK] = 1'b0;
    // clear count restarts while sysref is powered down or as the pulser powers up; only the readback flag waits on it
    clr_cnt_next = clr_cnt_reg;
    clr_ok_next  = clr_ok_reg;
    if (power_reg[srsd_pkg::PW_SR_PD] || power_reg[srsd_pkg::PW_PLSR_PD]
        && !power_next[srsd_pkg::PW_PLSR_PD]) begin
      clr_cnt_next = '0;
      clr_ok_next  = 1'b0;
    end else if (sync_reg[srsd_pkg::SC_CLR]) begin
      if (clr_cnt_reg != srsd_pkg::CLR_CYCLES) begin
        clr_cnt_next = clr_cnt_reg + 5'h01;
      end
      // complete once the clear has stood for the full count, not one cycle more
      clr_ok_next = (clr_cnt_next == srsd_pkg::CLR_CYCLES);
    end
    unique case (reg_addr_i)
      srsd_pkg::OFS_BURST:  rdata_next = burst_reg;
      srsd_pkg::OFS_POWER:  rdata_next = power_reg;
      srsd_pkg::OFS_SYNC:   rdata_next = {clr_ok_reg, sync_reg[srsd_pkg::SC_CLR_OK-1:0]};
      srsd_pkg::OFS_DIVBLK: rdata_next = divblk_reg;
      default:              rdata_next = '0;
    endcase
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      burst_reg   <= srsd_pkg::RST_BURST;
      power_reg   <= srsd_pkg::RST_POWER;
      sync_reg    <= srsd_pkg::RST_SYNC;
      divblk_reg  <= srsd_pkg::RST_DIVBLK;
      clr_cnt_reg <= '0;
      clr_ok_reg  <= 1'b0;
      reg_rdata_o <= '0;
    end else begin
      burst_reg   <= burst_next;
      power_reg   <= power_next;
      sync_reg    <= sync_next;
      divblk_reg  <= divblk_next;
      clr_cnt_reg <= clr_cnt_next;
      clr_ok_reg  <= clr_ok_next;
      reg_rdata_o <= rdata_next;
    end
  end

  srsd_pkg::srsd_mode_e mode;
  logic [1:0] src_sel, burst_code;
  logic pol, req_en, sync_en, sr_pd, plsr_pd, clr, sr_blk;
  assign mode       = srsd_pkg::srsd_mode_e'(sync_reg[srsd_pkg::SC_MODE_LSB +: 2]);
  assign src_sel    = burst_reg[srsd_pkg::BL_SRC_LSB +: 2];
  assign burst_code = burst_reg[srsd_pkg::BL_CODE_LSB +: 2];
  assign pol        = sync_reg[srsd_pkg::SC_POL];
  assign req_en     = sync_reg[srsd_pkg::SC_REQ_EN];
  assign sync_en    = sync_reg[srsd_pkg::SC_SYNC_EN];
  assign clr        = sync_reg[srsd_pkg::SC_CLR];
  assign sr_blk     = sync_reg[srsd_pkg::SC_SRBLK];
  assign sr_pd      = power_reg[srsd_pkg::PW_SR_PD];
  assign plsr_pd    = power_reg[srsd_pkg::PW_PLSR_PD];

  // ----------------------------------------------------------------
  // sysref divider, pulser and request
  // ----------------------------------------------------------------
  logic [SR_DIV_W-1:0] srcnt_reg, srcnt_next;
  logic [3:0] left_reg, left_next;
  logic       cont_reg, cont_next, trig_reg, trig_next, pin_pol;
  logic       sr_clk, sr_end, plsr_out, path, sr_hold;
  logic       path_reg, path_next;
  assign pin_pol = pin_s ^ pol;
  assign sr_clk  = srcnt_reg < (sysref_divide_i >> 1);
  assign sr_end  = srcnt_reg >= sysref_divide_i - SR_DIV_W'(1);
  assign sr_hold = path_reg && !sr_blk;
  always_comb begin
    srcnt_next = sr_end ? '0 : srcnt_reg + SR_DIV_W'(1);
    if (sr_pd || sr_hold) begin
      srcnt_next = '0;
    end
    trig_next = pin_pol;
    left_next = left_reg;
    cont_next = cont_reg;
    // a pulse opens only on a period edge and runs its whole high phase, so no runt
    if (sr_end) begin
      cont_next = (left_reg != 4'h0) || (req_en && pin_s);
      if (left_reg != 4'h0) begin
        left_next = left_reg - 4'h1;
      end
    end
    if (!plsr_pd && ((mode == srsd_pkg::SRSD_MODE_PLSP && pin_pol && !trig_reg)
        || (mode == srsd_pkg::SRSD_MODE_PLSW && burst_wr))) begin
      left_next = 4'h1 << burst_next[srsd_pkg::BL_CODE_LSB +: 2];
    end
    // powered-down sysref circuitry keeps no pending pulses for later
    if (sr_pd) begin
      left_next = 4'h0;
      cont_next = 1'b0;
    end
  end
  assign plsr_out = sr_clk && cont_reg && !sr_pd;
  always_comb begin
    unique case (src_sel)
      srsd_pkg::MUX_REF:
        path = (mode == srsd_pkg::SRSD_MODE_PIN) ? pin_pol
             : (mode == srsd_pkg::SRSD_MODE_OFF && plsr_pd) ? ref_s
             : 1'b0;
      srsd_pkg::MUX_RECLK: path = (mode == srsd_pkg::SRSD_MODE_PIN) && pin_pol;
      srsd_pkg::MUX_PLSR:  path = plsr_out;
      srsd_pkg::MUX_CONT:  path = sr_clk && !sr_pd;
    endcase
    path_next = path && sync_en && clk_ok_s;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      srcnt_reg <= '0;
      left_reg  <= '0;
      cont_reg  <= 1'b0;
      trig_reg  <= 1'b0;
      path_reg  <= 1'b0;
    end else begin
      srcnt_reg <= srcnt_next;
      left_reg  <= left_next;
      cont_reg  <= cont_next;
      trig_reg  <= trig_next;
      path_reg  <= path_next;
    end
  end

  // ----------------------------------------------------------------
  // local sysref delay buffer
  // ----------------------------------------------------------------
  logic [(1<<LDLY_W)-1:0] shb_reg, shb_next;
  logic sysref_next;
  always_comb begin
    shb_next    = clr ? '0 : {shb_reg[(1<<LDLY_W)-2:0], path_reg};
    sysref_next = !clr && !sr_pd && shb_reg[local_sysref_delay_i];
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shb_reg     <= '0;
      sysref_o    <= 1'b0;
      sync_path_o <= 1'b0;
    end else begin
      shb_reg     <= shb_next;
      sysref_o    <= sysref_next;
      sync_path_o <= path_next;
    end
  end

  // ----------------------------------------------------------------
  // device clock dividers
  // ----------------------------------------------------------------
  genvar g;
  for (g = 0; g < NDIV; g++) begin : g_div
    logic [9:0] cnt_reg, cnt_next, limit, ddly;
    logic       alt_reg, alt_next, out_next, hold;
    always_comb begin
      hold = path_reg && !divblk_reg[g];
      ddly = (dclk_cfg_i[g].ddly < srsd_pkg::DDLY_MIN) ? srsd_pkg::DDLY_MIN
           : dclk_cfg_i[g].ddly;
      limit = alt_reg ? ddly : dclk_cfg_i[g].div;
      cnt_next = (cnt_reg >= limit - 10'h001) ? 10'h000 : cnt_reg + 10'h001;
      alt_next = alt_reg && (cnt_reg < limit - 10'h001);
      if (hold) begin
        cnt_next = '0;
        alt_next = 1'b1;
      end
      out_next = !hold && !alt_next && cnt_next < (dclk_cfg_i[g].div >> 1);
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        cnt_reg        <= '0;
        alt_reg        <= 1'b0;
        dclk_o[g]      <= 1'b0;
        half_step_o[g] <= 1'b0;
      end else begin
        cnt_reg        <= cnt_next;
        alt_reg        <= alt_next;
        dclk_o[g]      <= out_next;
        half_step_o[g] <= dclk_cfg_i[g].hs;
      end
    end
  end
endmodule

//--- srsd_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module srsd_monitor #(
  parameter int unsigned NDIV = 4
) (
  input  wire logic                              clk_i,
  input  wire logic                              arst_n_i,
  input  wire logic                              reg_wr_i,
  input  wire logic [srsd_pkg::ADDR_W-1:0]       reg_addr_i,
  input  wire logic [srsd_pkg::DATA_W-1:0]       reg_wdata_i,
  input  wire logic [srsd_pkg::DATA_W-1:0]       reg_rdata_o,
  input  wire logic                              reference_input_zero_i,
  input  wire logic                              dist_clk_present_i,
  input  wire srsd_pkg::srsd_dclk_cfg_s [NDIV-1:0] dclk_cfg_i,
  input  wire logic [NDIV-1:0]                   dclk_o,
  input  wire logic [NDIV-1:0]                   half_step_o,
  input  wire logic                              sysref_o,
  input  wire logic                              sync_path_o
);
  logic [7:0] pw_reg;
  logic [7:0] sc_reg;
  logic [7:0] bl_reg;
  logic [7:0] bk_reg;
  logic       ref_cfg;
  // shadows lag a write by one cycle, as the registers do
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pw_reg <= srsd_pkg::RST_POWER;
      sc_reg <= srsd_pkg::RST_SYNC;
      bl_reg <= srsd_pkg::RST_BURST;
      bk_reg <= srsd_pkg::RST_DIVBLK;
    end else if (reg_wr_i) begin
      if (reg_addr_i == srsd_pkg::OFS_POWER) pw_reg <= reg_wdata_i;
      if (reg_addr_i == srsd_pkg::OFS_SYNC) sc_reg <= reg_wdata_i;
      if (reg_addr_i == srsd_pkg::OFS_BURST) bl_reg <= reg_wdata_i;
      if (reg_addr_i == srsd_pkg::OFS_DIVBLK) bk_reg <= reg_wdata_i;
    end
  end
  assign ref_cfg = sc_reg[2:1] == 2'h0 && bl_reg[3:2] == 2'h0 && pw_reg[0] && !pw_reg[2]
                   && sc_reg[4] && dist_clk_present_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  burst_readback_a: assert property (
    (reg_wr_i && reg_addr_i == srsd_pkg::OFS_BURST) ##1
    (!reg_wr_i && reg_addr_i == srsd_pkg::OFS_BURST) [*2]
    |-> reg_rdata_o[3:0] == $past(reg_wdata_i[3:0], 2)) else $error("burst readback");
  clear_mutes_a: assert property (
    sc_reg[5] && $past(sc_reg[5]) |-> !sysref_o) else $error("sysref while clear");
  pd_mutes_a: assert property (
    pw_reg[2] && $past(pw_reg[2]) |-> !sysref_o) else $error("sysref while down");
  ref_high_a: assert property (
    (ref_cfg && reference_input_zero_i) [*6] |-> sync_path_o) else $error("ref high lost");
  ref_low_a: assert property (
    (ref_cfg && !reference_input_zero_i) [*6] |-> !sync_path_o) else $error("ref low lost");
  div_hold_a: assert property (
    $past(sync_path_o) && $past(sync_path_o, 2) && $stable(bk_reg)
    |-> (dclk_o & ~bk_reg[NDIV-1:0]) == '0) else $error("divider not held");
  delay_low_a: assert property (
    $fell(sync_path_o) && !bk_reg[0] |-> !dclk_o[0] [*7]) else $error("delay too short");
  half_step_a: assert property (
    $past(arst_n_i) |-> half_step_o[0] == $past(dclk_cfg_i[0].hs)) else $error("half step");
endmodule
bind srsd_top srsd_monitor #(.NDIV(NDIV)) u_mon (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .reference_input_zero_i(reference_input_zero_i), .dist_clk_present_i(dist_clk_present_i),
  .dclk_cfg_i(dclk_cfg_i), .dclk_o(dclk_o), .half_step_o(half_step_o),
  .sysref_o(sysref_o), .sync_path_o(sync_path_o));

//--- srsd_conv_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// receiving converter
// ----------------------------------------
module srsd_conv_model (
  input  wire logic       clk_i,
  input  wire logic       clr_i,
  input  wire logic       sysref_i,
  input  wire logic       dclk_i,
  output logic      [7:0] pulse_cnt_o,
  output logic      [7:0] width_o,
  output logic      [7:0] edge_cnt_o
);
  logic       sr_q;
  logic       dk_q;
  logic [7:0] run;
  // width of the last pulse exposes a runt at burst end
  always_ff @(posedge clk_i) begin
    sr_q <= sysref_i;
    dk_q <= dclk_i;
    run <= sysref_i ? run + 8'h01 : 8'h00;
    if (sr_q && !sysref_i) width_o <= run;
    if (clr_i) begin
      pulse_cnt_o <= 8'h00;
      edge_cnt_o <= 8'h00;
    end else begin
      pulse_cnt_o <= pulse_cnt_o + 8'(sysref_i && !sr_q);
      edge_cnt_o <= edge_cnt_o + 8'(dclk_i && !dk_q);
    end
  end
endmodule

//--- sysref_sync_distribution_tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// bench
// ----------------------------------------
module sysref_sync_distribution_tb;
  logic                             clk_i = 1'b0;
  logic                             arst_n_i = 1'b0;
  logic                             wr = 1'b0;
  logic [11:0]                      ad = 12'h000;
  logic [7:0]                       wd = 8'h00;
  logic                             pin = 1'b0;
  logic                             ref0 = 1'b0;
  logic                             clr = 1'b1;
  logic                             dcp = 1'b1;
  srsd_pkg::srsd_dclk_cfg_s [3:0]   cfg;
  logic [7:0]                       rd;
  logic [3:0]                       dk;
  logic                             sr;
  logic                             sp;
  logic [7:0]                       pc;
  logic [7:0]                       wdt;
  logic [7:0]                       ec;
  logic [31:0]                      seed = 32'h8C6B6AFF;
  int                               bad_count = 0;
  int                               compares = 0;
  int                               cyc = 0;
  srsd_top #(.NDIV(4)) DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_wr_i(wr),
    .reg_addr_i(ad), .reg_wdata_i(wd), .reg_rdata_o(rd), .sync_pin_i(pin),
    .reference_input_zero_i(ref0), .dist_clk_present_i(dcp),
    .sysref_divide_i(13'h0010), .local_sysref_delay_i(4'h2), .dclk_cfg_i(cfg),
    .dclk_o(dk), .half_step_o(), .sysref_o(sr), .sync_path_o(sp));
  srsd_conv_model u_conv (.clk_i(clk_i), .clr_i(clr), .sysref_i(sr), .dclk_i(dk[0]),
    .pulse_cnt_o(pc), .width_o(wdt), .edge_cnt_o(ec));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] burst_n(input logic [1:0] c);
    return 8'h01 << c;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr <= 1'b1;
    ad <= a;
    wd <= d;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_i);
    ad <= a;
    repeat (2) @(posedge clk_i);
    #1 check(rd, e);
  endtask
  task automatic zero_conv();
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
  endtask
  task automatic burst(input logic [7:0] b, input logic [7:0] e);
    zero_conv();
    wr_reg(srsd_pkg::OFS_BURST, b);
    repeat (300) @(posedge clk_i);
    #1 check(pc, e);
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      cfg[i] = '{div: 10'h004, ddly: 10'h008, hs: seed[0]};
    end
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd_reg(srsd_pkg::OFS_BURST, srsd_pkg::RST_BURST);
    rd_reg(srsd_pkg::OFS_POWER, 8'h07);
    rd_reg(srsd_pkg::OFS_SYNC, 8'h20);
    rd_reg(12'h155, 8'h00);
    repeat (4) begin
      seed = xs(seed);
      wr_reg(srsd_pkg::OFS_BURST, seed[7:0] & 8'h0F);
      rd_reg(srsd_pkg::OFS_BURST, seed[7:0] & 8'h0F);
    end
    wr_reg(srsd_pkg::OFS_BURST, 8'h00);
    // host side order: power up, enable, hold clear, then manual sync
    wr_reg(srsd_pkg::OFS_POWER, 8'h00);
    wr_reg(srsd_pkg::OFS_SYNC, 8'h32);
    repeat (20) @(posedge clk_i);
    rd_reg(srsd_pkg::OFS_SYNC, 8'hB2);
    wr_reg(srsd_pkg::OFS_DIVBLK, 8'h00);
    // no distribution clock: the sync request must not reach the path
    dcp <= 1'b0;
    wr_reg(srsd_pkg::OFS_SYNC, 8'h33);
    repeat (4) @(posedge clk_i);
    #1 check({7'h00, sp}, 8'h00);
    @(posedge clk_i);
    dcp <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1 check({7'h00, sp}, 8'h01);
    wr_reg(srsd_pkg::OFS_SYNC, 8'h32);
    repeat (20) @(posedge clk_i);
    zero_conv();
    repeat (40) @(posedge clk_i);
    #1 check(ec, 8'h0A);
    wr_reg(srsd_pkg::OFS_DIVBLK, 8'h0F);
    wr_reg(srsd_pkg::OFS_SYNC, 8'h56);
    for (int c = 0; c < 4; c++) burst(8'h08 | 8'(c), burst_n(2'(c)));
    wr_reg(srsd_pkg::OFS_POWER, 8'h04);
    burst(8'h09, 8'h00);
    wr_reg(srsd_pkg::OFS_POWER, 8'h00);
    wr_reg(srsd_pkg::OFS_SYNC, 8'h74);
    repeat (16) @(posedge clk_i);
    wr_reg(srsd_pkg::OFS_SYNC, 8'h54);
    zero_conv();
    pin <= 1'b1;
    repeat (20) @(posedge clk_i);
    pin <= 1'b0;
    repeat (300) @(posedge clk_i);
    #1 check(pc, burst_n(2'h1));
    wr_reg(srsd_pkg::OFS_POWER, 8'h01);
    wr_reg(srsd_pkg::OFS_SYNC, 8'h58);
    zero_conv();
    pin <= 1'b1;
    repeat (84) @(posedge clk_i);
    pin <= 1'b0;
    repeat (60) @(posedge clk_i);
    #1 check(wdt, 8'h08);
    check({7'h00, pc == 8'h05 || pc == 8'h06}, 8'h01);
    wr_reg(srsd_pkg::OFS_BURST, 8'h00);
    wr_reg(srsd_pkg::OFS_SYNC, 8'h50);
    repeat (6) begin
      seed = xs(seed);
      ref0 <= seed[0];
      repeat (8) @(posedge clk_i);
      #1 check({7'h00, sp}, {7'h00, ref0});
    end
    // short continuous run only, the host is meant to keep it rare
    wr_reg(srsd_pkg::OFS_BURST, 8'h0C);
    repeat (16) @(posedge clk_i);
    zero_conv();
    repeat (64) @(posedge clk_i);
    #1 check(pc, 8'h04);
    wr_reg(srsd_pkg::OFS_BURST, 8'h04);
    wr_reg(srsd_pkg::OFS_SYNC, 8'h52);
    pin <= 1'b1;
    repeat (6) @(posedge clk_i);
    #1 check({7'h00, sp}, 8'h01);
    pin <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1 check({7'h00, sp}, 8'h00);
    close_out();
  end
endmodule
